// File: logic/regulator_power_down_control.sv
// regulator, power-on-reset and bandgap power-down control with apb registers
// assumes one 50 mhz clock, synchronous inputs and a synchronous reset
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// Local design decision: register access over APB.
`include "regpd_consts.svh"

module regulator_power_down_control
   import regpd_pkg::*;
#(
   parameter int unsigned BG_SETTLE_CYCLES = `RPC_BG_SETTLE_CYCLES
) (
   input wire logic CLK,
   input wire logic RESET,
   input wire apb_req_s APB_REQ,
   output apb_rsp_s APB_RSP,
   input wire logic WAKE_PIN_I,
   output logic WAKE_PIN_O,
   output logic WAKE_PIN_OE,
   input wire logic RTC_ALARM,
   output logic RTC_CLOCK_OUTPUT_ENABLE,
   output logic ANALOG_REGULATOR_ON,
   output logic USB_REGULATOR_ON,
   output logic USB_REGULATOR_OUTPUT_PIN_OE,
   output logic POR_ENABLE,
   output logic BANDGAP_ENABLE
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [4:0] pmgt;
   logic usb_regulator_enable;
   logic wake_seen;
   logic [`RPC_SETTLE_W-1:0] settle_cnt;
   pwr_state_e state;
   pwr_state_e next_state;
   logic [4:0] next_pmgt;
   logic next_usb_enable;
   logic [`RPC_SETTLE_W-1:0] next_settle_cnt;
   logic [31:0] next_rdata;
   logic [31:0] rdata;

   function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
      hit = (a == target);
   endfunction

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   wire access = APB_REQ.psel && APB_REQ.penable;
   wire setup_phase = APB_REQ.psel && !APB_REQ.penable;
   wire sel_pmgt = hit(APB_REQ.paddr, `RPC_RTC_PMGT_ADDR);
   wire sel_stat = hit(APB_REQ.paddr, `RPC_STATUS_ADDR);
   wire sel_ctrl = hit(APB_REQ.paddr, `RPC_REG_CTRL_ADDR);
   wire mapped = sel_pmgt || sel_stat || sel_ctrl;
   wire wr_pmgt = access && APB_REQ.pwrite && sel_pmgt;
   wire wr_ctrl = access && APB_REQ.pwrite && sel_ctrl;
   wire [31:0] wd = APB_REQ.pwdata;

   // ----------------------------------------------------------------
   // field views
   // ----------------------------------------------------------------
   wire bandgap_full_power_down = pmgt[`RPC_BANDGAP_FULL_POWER_DOWN_BIT];
   wire regulator_power_down = pmgt[`RPC_REG_PD_BIT];
   wire wake_pin_direction = pmgt[`RPC_WAKE_DIR_BIT];
   wire wake_pin_dout = pmgt[`RPC_WAKE_DOUT_BIT];
   wire any_pd = bandgap_full_power_down || regulator_power_down;
   wire settled = (settle_cnt == '0);

   // ----------------------------------------------------------------
   // wake qualification
   // ----------------------------------------------------------------
   wire pin_wake = WAKE_PIN_I && !wake_pin_direction;
   wire wake = any_pd && (pin_wake || RTC_ALARM);

   // ----------------------------------------------------------------
   // register next values
   // ----------------------------------------------------------------
   always_comb begin
      next_pmgt = pmgt;
      // wake drops both power-down bits, a write in the same cycle still lands
      if (wake) begin
         next_pmgt[`RPC_BANDGAP_FULL_POWER_DOWN_BIT] = 1'b0;
         next_pmgt[`RPC_REG_PD_BIT] = 1'b0;
      end
      if (wr_pmgt) begin
         next_pmgt[`RPC_CLKOUT_EN_BIT] = wd[`RPC_CLKOUT_EN_BIT];
         next_pmgt[`RPC_WAKE_DIR_BIT] = wd[`RPC_WAKE_DIR_BIT];
         next_pmgt[`RPC_WAKE_DOUT_BIT] = wd[`RPC_WAKE_DOUT_BIT];
         // power-down bits can be set by software but cleared only by wake
         next_pmgt[`RPC_BANDGAP_FULL_POWER_DOWN_BIT] = next_pmgt[`RPC_BANDGAP_FULL_POWER_DOWN_BIT] | wd[`RPC_BANDGAP_FULL_POWER_DOWN_BIT];
         next_pmgt[`RPC_REG_PD_BIT] = next_pmgt[`RPC_REG_PD_BIT] | wd[`RPC_REG_PD_BIT];
      end
   end

   // only bit 0 of the regulator control register is stored
   assign next_usb_enable = wr_ctrl ? wd[`RPC_USB_EN_BIT] : usb_regulator_enable;

   // ----------------------------------------------------------------
   // power state
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_settle_cnt = settle_cnt;
      case (state)
         PWR_ON: begin
            if (next_pmgt[`RPC_BANDGAP_FULL_POWER_DOWN_BIT]) begin
               next_state = PWR_BG_DOWN;
            end else if (next_pmgt[`RPC_REG_PD_BIT]) begin
               next_state = PWR_REG_DOWN;
            end
         end
         PWR_REG_DOWN: begin
            if (next_pmgt[`RPC_BANDGAP_FULL_POWER_DOWN_BIT]) begin
               next_state = PWR_BG_DOWN;
            end else if (!next_pmgt[`RPC_REG_PD_BIT]) begin
               next_state = PWR_ON;
            end
         end
         PWR_BG_DOWN: begin
            // bandgap recharge time is tracked after its wake
            if (!next_pmgt[`RPC_BANDGAP_FULL_POWER_DOWN_BIT] && !next_pmgt[`RPC_REG_PD_BIT]) begin
               next_state = PWR_BG_SETTLE;
               next_settle_cnt = `RPC_SETTLE_W'(BG_SETTLE_CYCLES - 1);
            end
         end
         PWR_BG_SETTLE: begin
            if (next_pmgt[`RPC_BANDGAP_FULL_POWER_DOWN_BIT]) begin
               next_state = PWR_BG_DOWN;
               next_settle_cnt = '0;
            end else if (next_pmgt[`RPC_REG_PD_BIT]) begin
               next_state = PWR_REG_DOWN;
               next_settle_cnt = '0;
            end else if (settled) begin
               next_state = PWR_ON;
               next_settle_cnt = '0;
            end else begin
               next_settle_cnt = settle_cnt - `RPC_SETTLE_W'(1);
            end
         end
         default: begin
            next_state = PWR_ON;
            next_settle_cnt = '0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   always_comb begin
      next_rdata = '0;
      if (sel_pmgt) begin
         next_rdata[4:0] = pmgt;
      end else if (sel_ctrl) begin
         next_rdata[`RPC_USB_EN_BIT] = usb_regulator_enable;
      end else if (sel_stat) begin
         next_rdata[`RPC_BG_SETTLED_BIT] = (state != PWR_BG_SETTLE) && !bandgap_full_power_down;
         next_rdata[`RPC_WAKE_SEEN_BIT] = wake_seen;
      end
   end

   assign APB_RSP.pready = 1'b1;
   assign APB_RSP.pslverr = access && !mapped;
   // read data held from the setup cycle
   assign APB_RSP.prdata = rdata;

   // ----------------------------------------------------------------
   // state registers
   // ----------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RESET) begin
         pmgt <= `RPC_PMGT_RESET;
         usb_regulator_enable <= `RPC_USB_EN_RESET;
         state <= PWR_ON;
         settle_cnt <= '0;
         wake_seen <= 1'b0;
         rdata <= '0;
      end else begin
         pmgt <= next_pmgt;
         usb_regulator_enable <= next_usb_enable;
         state <= next_state;
         settle_cnt <= next_settle_cnt;
         if (setup_phase) begin
            rdata <= next_rdata;
         end
         // sticky wake flag, a wake beats the software clear
         if (wake) begin
            wake_seen <= 1'b1;
         end else if (access && APB_REQ.pwrite && sel_stat && wd[`RPC_WAKE_SEEN_BIT]) begin
            wake_seen <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // analog controls, registered
   // ----------------------------------------------------------------
   wire next_reg_on = !next_pmgt[`RPC_BANDGAP_FULL_POWER_DOWN_BIT] && !next_pmgt[`RPC_REG_PD_BIT];

   always_ff @(posedge CLK) begin
      if (RESET) begin
         ANALOG_REGULATOR_ON <= 1'b1;
         USB_REGULATOR_ON <= 1'b0;
         USB_REGULATOR_OUTPUT_PIN_OE <= 1'b0;
         POR_ENABLE <= 1'b1;
         BANDGAP_ENABLE <= 1'b1;
         RTC_CLOCK_OUTPUT_ENABLE <= 1'b0;
         WAKE_PIN_OE <= 1'b0;
      end else begin
         ANALOG_REGULATOR_ON <= next_reg_on;
         USB_REGULATOR_ON <= next_reg_on && next_usb_enable;
         USB_REGULATOR_OUTPUT_PIN_OE <= next_reg_on && next_usb_enable;
         POR_ENABLE <= next_reg_on;
         BANDGAP_ENABLE <= !next_pmgt[`RPC_BANDGAP_FULL_POWER_DOWN_BIT];
         RTC_CLOCK_OUTPUT_ENABLE <= next_pmgt[`RPC_CLKOUT_EN_BIT];
         WAKE_PIN_OE <= next_pmgt[`RPC_WAKE_DIR_BIT] && !next_pmgt[`RPC_WAKE_DOUT_BIT];
      end
   end

   // open-drain wake output only ever pulls low
   assign WAKE_PIN_O = 1'b0;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);

   property p_bg_down;
      bandgap_full_power_down
         |-> !BANDGAP_ENABLE && !ANALOG_REGULATOR_ON && !POR_ENABLE && !USB_REGULATOR_ON;
   endproperty
   a_bg_down: assert property (p_bg_down) else $error("bandgap not off");

   property p_reg_down_keeps_bg;
      regulator_power_down && !bandgap_full_power_down
         |-> !ANALOG_REGULATOR_ON && !POR_ENABLE && BANDGAP_ENABLE;
   endproperty
   a_reg_down_keeps_bg: assert property (p_reg_down_keeps_bg)
      else $error("regulator power-down wrong");

   property p_only_wake;
      any_pd && !wake |=> any_pd;
   endproperty
   a_only_wake: assert property (p_only_wake) else $error("power-down left without wake");

   property p_settle_len;
      state == PWR_BG_DOWN && next_state == PWR_BG_SETTLE
         |=> settle_cnt == `RPC_SETTLE_W'(BG_SETTLE_CYCLES - 1);
   endproperty
   a_settle_len: assert property (p_settle_len) else $error("settle count wrong");

   property p_clkout;
      wr_pmgt |=> RTC_CLOCK_OUTPUT_ENABLE == $past(wd[`RPC_CLKOUT_EN_BIT]);
   endproperty
   a_clkout: assert property (p_clkout) else $error("clock output enable wrong");

   property p_usb_matrix;
      USB_REGULATOR_ON == (!any_pd && usb_regulator_enable)
         && USB_REGULATOR_OUTPUT_PIN_OE == USB_REGULATOR_ON;
   endproperty
   a_usb_matrix: assert property (p_usb_matrix) else $error("usb regulator wrong");

   property p_reserved;
      access && !APB_REQ.pwrite && sel_ctrl |-> APB_RSP.prdata[31:1] == '0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

   property p_matrix;
      ANALOG_REGULATOR_ON == (!bandgap_full_power_down && !regulator_power_down);
   endproperty
   a_matrix: assert property (p_matrix) else $error("analog regulator wrong");

   property p_pin_dir;
      any_pd && wake_pin_direction && !RTC_ALARM |=> any_pd;
   endproperty
   a_pin_dir: assert property (p_pin_dir) else $error("output pin woke device");

   property p_wake_clear;
      wake && !wr_pmgt
         |=> !any_pd && ANALOG_REGULATOR_ON && POR_ENABLE && BANDGAP_ENABLE;
   endproperty
   a_wake_clear: assert property (p_wake_clear) else $error("wake did not clear");

   property p_usb_reset;
      $fell(RESET)
         |-> !usb_regulator_enable && !USB_REGULATOR_ON && !USB_REGULATOR_OUTPUT_PIN_OE;
   endproperty
   a_usb_reset: assert property (p_usb_reset) else $error("usb regulator on after reset");

endmodule

// File: logic/regpd_consts.svh
// offsets, field positions, reset values and timing counts of the
// regulator power-down control block; included by top and testbench
`ifndef REGPD_CONSTS_SVH
`define REGPD_CONSTS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define RPC_RTC_PMGT_ADDR 16'h1930
`define RPC_STATUS_ADDR 16'h1934
`define RPC_REG_CTRL_ADDR 16'h7004

// ----------------------------------------------------------------
// rtc power management fields
// ----------------------------------------------------------------
`define RPC_CLKOUT_EN_BIT 0
`define RPC_REG_PD_BIT 1
`define RPC_BANDGAP_FULL_POWER_DOWN_BIT 2
`define RPC_WAKE_DIR_BIT 3
`define RPC_WAKE_DOUT_BIT 4

// ----------------------------------------------------------------
// regulator control and status fields
// ----------------------------------------------------------------
`define RPC_USB_EN_BIT 0
`define RPC_BG_SETTLED_BIT 0
`define RPC_WAKE_SEEN_BIT 1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RPC_PMGT_RESET 5'h10
`define RPC_USB_EN_RESET 1'b0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RPC_CLK_KHZ 50000
`define RPC_BG_SETTLE_MS 100
`define RPC_BG_SETTLE_CYCLES (`RPC_BG_SETTLE_MS * `RPC_CLK_KHZ)
`define RPC_SETTLE_W 23

`endif

// File: logic/regpd_pkg.sv
// types of the regulator power-down control block
// assumes a 16-bit apb address and 32-bit data path
package regpd_pkg;

   // ----------------------------------------------------------------
   // apb carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [15:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_s;

   // ----------------------------------------------------------------
   // power states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PWR_ON = 2'b00,
      PWR_REG_DOWN = 2'b01,
      PWR_BG_DOWN = 2'b10,
      PWR_BG_SETTLE = 2'b11
   } pwr_state_e;

endpackage

// File: tb/regpd_partner.sv
// bench model of the wake sources and the bandgap reference capacitor
// assumes an external pull-up on the wake pin and an open-drain pin driver
module regpd_partner #(
   parameter int SETTLE = 8
) (
   input wire logic clk,
   input wire logic wake_req,
   input wire logic alarm_req,
   input wire logic pin_o,
   input wire logic pin_oe,
   input wire logic bandgap_on,
   output logic wake_level,
   output logic alarm,
   output logic ref_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   int charge = 0;
   // pin pulled low by the block wins over the source
   assign wake_level = (pin_oe && !pin_o) ? 1'b0 : wake_req;
   assign alarm = alarm_req;
   // capacitor recharges only once the bandgap is back
   always @(posedge clk) begin
      if (!bandgap_on) charge <= 0;
      else if (charge < SETTLE) charge <= charge + 1;
   end
   assign ref_ready = (charge >= SETTLE);
endmodule

// File: tb/testbench.sv
// self-checking bench of the regulator power-down control block
// assumes regpd_pkg, the constants header and the partner model
`include "regpd_consts.svh"
module testbench
   import regpd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SETTLE = 8;
   logic clk = 0, reset = 1, wake_req = 0, alarm_req = 0, er, ck;
   apb_req_s req = '0;
   apb_rsp_s rsp;
   logic wake_o, wake_oe, wake_level, alarm, ref_ready;
   logic clk_out, ana_on, usb_on, usb_oe, por_on, bg_on;
   logic [31:0] rd;
   int err_count = 0;
   int n_checks = 0;
   wire [31:0] pwr = {27'h0, ana_on, usb_on, usb_oe, por_on, bg_on};
   // ----------------------------------------------------------------
   // design and far side
   // ----------------------------------------------------------------
   regulator_power_down_control #(.BG_SETTLE_CYCLES(SETTLE)) i_regulator_power_down_control (
      .CLK(clk), .RESET(reset), .APB_REQ(req), .APB_RSP(rsp),
      .WAKE_PIN_I(wake_level), .WAKE_PIN_O(wake_o), .WAKE_PIN_OE(wake_oe),
      .RTC_ALARM(alarm), .RTC_CLOCK_OUTPUT_ENABLE(clk_out),
      .ANALOG_REGULATOR_ON(ana_on), .USB_REGULATOR_ON(usb_on),
      .USB_REGULATOR_OUTPUT_PIN_OE(usb_oe), .POR_ENABLE(por_on), .BANDGAP_ENABLE(bg_on));
   regpd_partner #(.SETTLE(SETTLE)) i_regpd_partner (
      .clk(clk), .wake_req(wake_req), .alarm_req(alarm_req), .pin_o(wake_o),
      .pin_oe(wake_oe), .bandgap_on(bg_on), .wake_level(wake_level), .alarm(alarm),
      .ref_ready(ref_ready));
   initial begin
      forever #10 clk = ~clk;
   end
   // ----------------------------------------------------------------
   // tasks and expectations
   // ----------------------------------------------------------------
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      req.paddr <= a;
      req.pwrite <= w;
      req.pwdata <= d;
      req.psel <= 1'b1;
      req.penable <= 1'b0;
      @(posedge clk);
      req.penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      er = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic pulse(input logic pin);
      if (pin) wake_req <= 1'b1;
      else alarm_req <= 1'b1;
      @(posedge clk);
      wake_req <= 1'b0;
      alarm_req <= 1'b0;
      @(posedge clk);
   endtask
   function automatic logic [31:0] exp_pwr(input logic bg, input logic rg, input logic usb);
      logic on;
      on = !bg && !rg;
      return {27'h0, on, on && usb, on && usb, on, !bg};
   endfunction
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] d;
      d = $urandom(32'h0000_58e5);
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      chk("power outputs", exp_pwr(0, 0, 0), pwr);
      chk("clock out enable", 32'h0, {31'h0, clk_out});
      apb(0, `RPC_RTC_PMGT_ADDR, 32'h0);
      chk("pmgt reset", 32'h0000_0010, rd);
      apb(0, `RPC_REG_CTRL_ADDR, 32'h0);
      chk("ctrl reset", 32'h0, rd);
      repeat (4) begin
         d = $urandom;
         apb(1, `RPC_REG_CTRL_ADDR, d);
         apb(0, `RPC_REG_CTRL_ADDR, 32'h0);
         chk("ctrl readback", {31'h0, d[0]}, rd);
         chk("power outputs", exp_pwr(0, 0, d[0]), pwr);
      end
      // regulators in use here, so power-down bits are allowed
      for (int i = 0; i < 8; i++) begin
         ck = 1'($urandom_range(1));
         apb(1, `RPC_REG_CTRL_ADDR, {31'h0, i[0]});
         apb(1, `RPC_RTC_PMGT_ADDR, 32'h0000_0010 | {29'h0, i[2], i[1], ck});
         chk("power outputs", exp_pwr(i[2], i[1], i[0]), pwr);
         chk("clock out enable", {31'h0, ck}, {31'h0, clk_out});
         if (i[2] | i[1]) begin
            apb(1, `RPC_RTC_PMGT_ADDR, 32'h0000_0010 | {31'h0, ck});
            chk("power outputs", exp_pwr(i[2], i[1], i[0]), pwr);
            pulse(0);
            chk("power outputs", exp_pwr(0, 0, i[0]), pwr);
            apb(0, `RPC_RTC_PMGT_ADDR, 32'h0);
            chk("pmgt after wake", 32'h0000_0010 | {31'h0, ck}, rd);
            if (i[2]) begin
               apb(0, `RPC_STATUS_ADDR, 32'h0);
               chk("bandgap settled", 32'h0, rd & 32'h1);
               repeat (SETTLE + 2) @(posedge clk);
               chk("reference ready", 32'h1, {31'h0, ref_ready});
               apb(0, `RPC_STATUS_ADDR, 32'h0);
               chk("bandgap settled", 32'h1, rd & 32'h1);
            end
         end
      end
      apb(1, `RPC_RTC_PMGT_ADDR, 32'h0000_001a);
      chk("pin output enable", 32'h0, {31'h0, wake_oe});
      pulse(1);
      chk("power outputs", exp_pwr(0, 1, 1), pwr);
      apb(1, `RPC_RTC_PMGT_ADDR, 32'h0000_0012);
      pulse(1);
      chk("power outputs", exp_pwr(0, 0, 1), pwr);
      apb(0, `RPC_STATUS_ADDR, 32'h0);
      chk("wake seen", 32'h2, rd & 32'h2);
      apb(1, `RPC_STATUS_ADDR, 32'h2);
      apb(0, `RPC_STATUS_ADDR, 32'h0);
      chk("wake seen cleared", 32'h0, rd & 32'h2);
      apb(1, `RPC_RTC_PMGT_ADDR, 32'h0000_0008);
      chk("pin output enable", 32'h1, {31'h0, wake_oe});
      chk("pin drive level", 32'h0, {31'h0, wake_o});
      apb(0, 16'h0100, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, er});
      chk("unmapped data", 32'h0, rd);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      chk("power outputs", exp_pwr(0, 0, 0), pwr);
      chk("pin output enable", 32'h0, {31'h0, wake_oe});
      apb(0, `RPC_REG_CTRL_ADDR, 32'h0);
      chk("ctrl reset", 32'h0, rd);
      close_out();
   end
   initial begin
      #400000;
      err_count++;
      close_out();
   end
endmodule
